// ==== sfs_pkg.sv ====
package sfs_pkg;
  // bus geometry
  localparam int DATA_W = 16;
  localparam int SEL_W = 2;
  localparam int NUM_FIFO = 4;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  // reset values
  localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  // timing: address setup and interface clock limits
  localparam int SYS_PERIOD_PS = 5000;
  localparam int ADDR_SETUP_PS = 25000;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int IFACE_CLK_MIN_PERIOD_PS = 20830;
  localparam int IFACE_CLK_HALF_CYC = (IFACE_CLK_MIN_PERIOD_PS + 2 * SYS_PERIOD_PS - 1) / (2 * SYS_PERIOD_PS);
  // master sequencer commands
  typedef enum logic [1:0] {SFS_CMD_READ, SFS_CMD_WRITE, SFS_CMD_COMMIT} sfs_cmd_t;
endpackage : sfs_pkg

// ==== sfs_if.sv ====
`timescale 1ns/1ps
interface sfs_if;
  import sfs_pkg::*;
  logic iface_clk;
  logic slave_chip_select_n;
  logic slave_read_strobe_n;
  logic slave_write_strobe_n;
  logic slave_output_enable_n;
  logic packet_commit_strobe_n;
  logic [SEL_W-1:0] fifo_select_lines;
  logic [DATA_W-1:0] dev_data_out;
  logic dev_data_oe;
  logic [DATA_W-1:0] mst_data_out;
  logic mst_data_oe;
  logic [DATA_W-1:0] data_in;
  logic [NUM_FIFO-1:0] empty_flag_n;
  logic [NUM_FIFO-1:0] full_flag_n;
  modport device (
    output iface_clk, output dev_data_out, output dev_data_oe,
    output empty_flag_n, output full_flag_n,
    input slave_chip_select_n, input slave_read_strobe_n, input slave_write_strobe_n,
    input slave_output_enable_n, input packet_commit_strobe_n, input fifo_select_lines,
    input data_in
  );
  modport master (
    input iface_clk, input dev_data_out, input dev_data_oe,
    input empty_flag_n, input full_flag_n,
    output slave_chip_select_n, output slave_read_strobe_n, output slave_write_strobe_n,
    output slave_output_enable_n, output packet_commit_strobe_n, output fifo_select_lines,
    output mst_data_out, output mst_data_oe,
    input data_in
  );
endinterface : sfs_if

// ==== sfs_device.sv ====
`timescale 1ns/1ps
module sfs_device
  import sfs_pkg::*;
#(
  parameter int NFIFO = NUM_FIFO,
  parameter int DEPTH_P = DEPTH
)(
  // system
  input wire logic SYS_CLK,
  input wire logic RST,
  // link
  sfs_if.device LINK,
  // user side: host drain of committed words
  input wire logic [SEL_W-1:0] USER_SEL,
  input wire logic USER_POP,
  output logic [DATA_W-1:0] USER_DATA,
  output logic [CNT_W-1:0] USER_COMMITTED,
  output logic [CNT_W-1:0] USER_PACKETS
);
  import sfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // true when a select value names fifo idx
  function automatic logic sel_hit(input logic [SEL_W-1:0] a, input int idx);
    return (a == SEL_W'(idx));
  endfunction : sel_hit

  ////////////////////////////////////////////////////////////////////////////
  // storage and pointers
  // each fifo keeps its own read and write pointer and a fill count;
  // the fill count is one bit wider than the pointers, so full and empty
  // are told apart without giving up a slot of storage
  // the read pointer is shared by the link reader and the host drain,
  // so one fifo is meant to be emptied by only one of them at a time
  logic [DATA_W-1:0] mem [NUM_FIFO][DEPTH];
  logic [PTR_W-1:0] rd_ptr [NUM_FIFO];
  logic [PTR_W-1:0] wr_ptr [NUM_FIFO];
  logic [CNT_W-1:0] fill [NUM_FIFO];
  logic [CNT_W-1:0] committed [NUM_FIFO];
  logic [CNT_W-1:0] packets [NUM_FIFO];
  logic [CNT_W-1:0] clk_div;
  logic clk_q;
  logic prev_clk;
  logic [DATA_W-1:0] dev_data;
  logic dev_oe;
  logic [NUM_FIFO-1:0] ef_n;
  logic [NUM_FIFO-1:0] ff_n;
  logic [DATA_W-1:0] user_data;
  logic [CNT_W-1:0] user_committed;
  logic [CNT_W-1:0] user_packets;

  // all link inputs but the output enable and the select lines are taken only on the sys edge
  // after an interface clock rise, so the link behaves as if clocked by it; the select lines also pick the prefetched word on every sys edge;
  // a read of an empty fifo or a write to a full one is dropped
  // silently, the flags tell the master not to try
  // decode of qualified strobes
  wire sel_ok = ~LINK.slave_chip_select_n;
  wire rise = clk_q & ~prev_clk;
  wire [SEL_W-1:0] fsel = LINK.fifo_select_lines;
  wire do_rd = rise & sel_ok & ~LINK.slave_read_strobe_n & (fill[fsel] != CNT_RST);
  wire do_wr = rise & sel_ok & ~LINK.slave_write_strobe_n & (fill[fsel] != CNT_W'(DEPTH));
  wire do_pe = rise & sel_ok & ~LINK.packet_commit_strobe_n;
  wire user_pop = USER_POP & (committed[USER_SEL] != CNT_RST);
  wire [PTR_W-1:0] next_rd = rd_ptr[fsel] + PTR_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // interface clock divider, half period counted up
  // the half period is rounded up to whole sys cycles, so the link
  // clock is never faster than its limit; the rise is seen one sys
  // cycle late through prev_clk, which gives the master its setup
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      clk_div <= CNT_RST;
      clk_q <= 1'b0;
      prev_clk <= 1'b0;
    end
    else
    begin
      prev_clk <= clk_q;
      if (clk_div == CNT_W'(IFACE_CLK_HALF_CYC - 1))
      begin
        clk_div <= CNT_RST;
        clk_q <= ~clk_q;
      end
      else
        clk_div <= clk_div + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo state per select line
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NUM_FIFO; i++)
      begin
        rd_ptr[i] <= PTR_RST;
        wr_ptr[i] <= PTR_RST;
        fill[i] <= CNT_RST;
        committed[i] <= CNT_RST;
        packets[i] <= CNT_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_FIFO; i++)
      begin
        logic wr_i;
        logic rd_i;
        logic pe_i;
        logic pop_i;
        wr_i = do_wr & sel_hit(fsel, i);
        rd_i = do_rd & sel_hit(fsel, i);
        pe_i = do_pe & sel_hit(fsel, i);
        pop_i = user_pop & sel_hit(USER_SEL, i);
        // the write lands in the slot under the write pointer, the
        // read pointer moves past the word that the bus already showed
        if (wr_i)
        begin
          mem[i][wr_ptr[i]] <= LINK.data_in;
          wr_ptr[i] <= wr_ptr[i] + PTR_W'(1);
        end
        if (rd_i | pop_i)
          rd_ptr[i] <= rd_ptr[i] + PTR_W'(1);
        fill[i] <= fill[i] + CNT_W'(wr_i) - CNT_W'(rd_i | pop_i);
        // commit covers every word written, including same edge
        if (pe_i)
          committed[i] <= fill[i] + CNT_W'(wr_i) - CNT_W'(rd_i | pop_i);
        else
          committed[i] <= committed[i] - CNT_W'(pop_i & (committed[i] != CNT_RST));
        if (pe_i)
          packets[i] <= packets[i] + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: prefetched data, enable, flags
  // the word after a read is fetched on the same edge, so the next
  // word is on the bus right after the read edge itself; flags are
  // built from the fill count before the edge and so follow it by one
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      dev_data <= '0;
      dev_oe <= 1'b0;
      ef_n <= '0;
      ff_n <= '1;
      user_data <= '0;
      user_committed <= CNT_RST;
      user_packets <= CNT_RST;
    end
    else
    begin
      dev_data <= do_rd ? mem[fsel][next_rd] : mem[fsel][rd_ptr[fsel]];
      dev_oe <= ~LINK.slave_output_enable_n;
      for (int i = 0; i < NUM_FIFO; i++)
      begin
        ef_n[i] <= (fill[i] != CNT_RST);
        ff_n[i] <= (fill[i] != CNT_W'(DEPTH));
      end
      user_data <= mem[USER_SEL][rd_ptr[USER_SEL]];
      user_committed <= committed[USER_SEL];
      user_packets <= packets[USER_SEL];
    end
  end

  assign LINK.iface_clk = clk_q;
  assign LINK.dev_data_out = dev_data;
  assign LINK.dev_data_oe = dev_oe;
  assign LINK.empty_flag_n = ef_n;
  assign LINK.full_flag_n = ff_n;
  assign USER_DATA = user_data;
  // host view, one sys cycle behind the counters
  assign USER_COMMITTED = user_committed;
  assign USER_PACKETS = user_packets;
endmodule : sfs_device

// ==== sfs_master.sv ====
`timescale 1ns/1ps
module sfs_master
  import sfs_pkg::*;
(
  // system
  input wire logic SYS_CLK,
  input wire logic RST,
  // link
  sfs_if.master LINK,
  // user command
  input wire logic CMD_VALID,
  input wire sfs_pkg::sfs_cmd_t CMD,
  input wire logic [SEL_W-1:0] CMD_SEL,
  input wire logic [DATA_W-1:0] CMD_DATA,
  output logic CMD_READY,
  output logic [DATA_W-1:0] RD_DATA,
  output logic RD_VALID
);
  import sfs_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_XFER, ST_DONE} sfs_state_t;
  sfs_state_t state;
  sfs_cmd_t cmd;
  logic [CNT_W-1:0] setup_cnt;
  logic prev_clk;
  logic cs_n, rd_n, wr_n, oe_n, pe_n, doe, rdy, rvalid;
  logic [SEL_W-1:0] sel;
  logic [DATA_W-1:0] wdata, rdata;
  wire rise = LINK.iface_clk & ~prev_clk;

  ////////////////////////////////////////////////////////////////////////////
  // one transfer: select setup, strobe for one interface edge, release
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      cmd <= SFS_CMD_READ;
      setup_cnt <= CNT_RST;
      prev_clk <= 1'b0;
      {cs_n, rd_n, wr_n, oe_n, pe_n} <= 5'h1F;
      doe <= 1'b0;
      rdy <= 1'b0;
      rvalid <= 1'b0;
      sel <= '0;
      wdata <= '0;
      rdata <= '0;
    end
    else
    begin
      prev_clk <= LINK.iface_clk;
      rvalid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          rdy <= 1'b1;
          if (CMD_VALID & rdy)
          begin
            rdy <= 1'b0;
            cmd <= CMD;
            sel <= CMD_SEL;
            wdata <= CMD_DATA;
            cs_n <= 1'b0;
            doe <= (CMD == SFS_CMD_WRITE);
            oe_n <= ~(CMD == SFS_CMD_READ);
            setup_cnt <= CNT_RST;
            state <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // address held 25 ns before the strobe goes out
          if (setup_cnt == CNT_W'(ADDR_SETUP_CYC))
          begin
            if (rise)
            begin
              rd_n <= ~(cmd == SFS_CMD_READ);
              wr_n <= ~(cmd == SFS_CMD_WRITE);
              pe_n <= ~(cmd == SFS_CMD_COMMIT);
              state <= ST_XFER;
            end
          end
          else
            setup_cnt <= setup_cnt + CNT_W'(1);
        end
        ST_XFER:
        begin
          if (rise)
          begin
            rdata <= LINK.data_in;
            rvalid <= (cmd == SFS_CMD_READ);
            {rd_n, wr_n, pe_n} <= 3'h7;
            state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          {cs_n, oe_n} <= 2'h3;
          doe <= 1'b0;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  assign LINK.slave_chip_select_n = cs_n;
  assign LINK.slave_read_strobe_n = rd_n;
  assign LINK.slave_write_strobe_n = wr_n;
  assign LINK.slave_output_enable_n = oe_n;
  assign LINK.packet_commit_strobe_n = pe_n;
  assign LINK.fifo_select_lines = sel;
  assign LINK.mst_data_out = wdata;
  assign LINK.mst_data_oe = doe;
  assign CMD_READY = rdy;
  assign RD_DATA = rdata;
  assign RD_VALID = rvalid;
endmodule : sfs_master

// ==== sfs_link_props.sv ====
`timescale 1ns/1ps
module sfs_link_props
  import sfs_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // link signals
  input wire logic iface_clk,
  input wire logic slave_chip_select_n,
  input wire logic slave_read_strobe_n,
  input wire logic slave_write_strobe_n,
  input wire logic slave_output_enable_n,
  input wire logic packet_commit_strobe_n,
  input wire logic [SEL_W-1:0] fifo_select_lines,
  input wire logic dev_data_oe,
  input wire logic [NUM_FIFO-1:0] empty_flag_n,
  input wire logic [NUM_FIFO-1:0] full_flag_n
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  // link clock, bus drive and strobe qualification
  property p_clk_hold;
    $rose(iface_clk) |-> iface_clk[*3];
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("link clock high too short");
  property p_oe_on;
    !slave_output_enable_n && !$past(slave_output_enable_n) |-> dev_data_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven under enable");
  property p_oe_off;
    slave_output_enable_n && $past(slave_output_enable_n) |-> !dev_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven without enable");
  property p_rd_cs;
    !slave_read_strobe_n |-> !slave_chip_select_n;
  endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read strobe without select");
  property p_wr_cs;
    !slave_write_strobe_n |-> !slave_chip_select_n;
  endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("write strobe without select");
  property p_commit_sel;
    !packet_commit_strobe_n && !$past(packet_commit_strobe_n) |-> $stable(fifo_select_lines);
  endproperty
  a_commit_sel: assert property (p_commit_sel) else $error("select moved during commit");
  ////////////////////////////////////////////////////////////
  // flag behaviour of fifo 0
  property p_cs_idle;
    slave_chip_select_n && $past(slave_chip_select_n) && $past(slave_chip_select_n, 2)
      |-> $stable(empty_flag_n[0]) && $stable(full_flag_n[0]);
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("flags moved while deselected");
  property p_full_by_write;
    $fell(full_flag_n[0]) |-> !$past(slave_write_strobe_n) || !$past(slave_write_strobe_n, 2);
  endproperty
  a_full_by_write: assert property (p_full_by_write) else $error("full without write");
  // main scenarios reached
  c_read: cover property (!slave_read_strobe_n && dev_data_oe);
  c_commit: cover property (!packet_commit_strobe_n);
  c_full: cover property ($fell(full_flag_n[0]));
endmodule : sfs_link_props

// ==== test_slave_fifo_sync_port.sv ====
`timescale 1ns/1ps
module test_slave_fifo_sync_port;
  import sfs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  sfs_cmd_t cmd_op = SFS_CMD_READ;
  logic [SEL_W-1:0] cmd_sel = 2'h0;
  logic [DATA_W-1:0] cmd_data = 16'h0000;
  logic [SEL_W-1:0] user_sel = 2'h1;
  logic user_pop = 1'b0;
  logic [DATA_W-1:0] idle_pat = 16'h0000;
  logic cmd_ready, rd_valid;
  logic [DATA_W-1:0] rd_data, user_data;
  logic [CNT_W-1:0] user_committed, user_packets;
  int n_errors = 0;
  int num_checks = 0;
  sfs_if bus();
  ////////////////////////////////////////////////////////////
  // clock, undriven bus pattern and resolved bus
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) idle_pat <= idle_pat + 16'h1357;
  assign bus.data_in = bus.dev_data_oe ? bus.dev_data_out : (bus.mst_data_oe ? bus.mst_data_out : idle_pat);
  sfs_device sfs_device_inst (.SYS_CLK(sys_clk), .RST(rst), .LINK(bus), .USER_SEL(user_sel),
    .USER_POP(user_pop), .USER_DATA(user_data), .USER_COMMITTED(user_committed), .USER_PACKETS(user_packets));
  sfs_master sfs_master_inst (.SYS_CLK(sys_clk), .RST(rst), .LINK(bus), .CMD_VALID(cmd_valid), .CMD(cmd_op),
    .CMD_SEL(cmd_sel), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid));
  sfs_link_props sfs_link_props_inst (.SYS_CLK(sys_clk), .RST(rst), .iface_clk(bus.iface_clk),
    .slave_chip_select_n(bus.slave_chip_select_n), .slave_read_strobe_n(bus.slave_read_strobe_n),
    .slave_write_strobe_n(bus.slave_write_strobe_n), .slave_output_enable_n(bus.slave_output_enable_n),
    .packet_commit_strobe_n(bus.packet_commit_strobe_n), .fifo_select_lines(bus.fifo_select_lines),
    .dev_data_oe(bus.dev_data_oe), .empty_flag_n(bus.empty_flag_n), .full_flag_n(bus.full_flag_n));
  ////////////////////////////////////////////////////////////
  // compare, verdict and command tasks
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // waits at falling edges until the master is ready again
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 500) n_errors++;
  endtask : wait_ready
  task automatic cmd(input sfs_cmd_t c, input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] d,
                     input logic [DATA_W-1:0] exp);
    int n;
    wait_ready();
    cmd_valid = 1'b1;
    cmd_op = c;
    cmd_sel = s;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (c == SFS_CMD_READ && rd_valid !== 1'b1 && n < 500)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (c == SFS_CMD_READ) check("read data", rd_data, exp);
  endtask : cmd
  ////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    for (int i = 0; i < DEPTH; i++) cmd(SFS_CMD_WRITE, 2'h0, 16'hA000 + 16'(i), 16'h0000);
    wait_ready();
    repeat (2) @(negedge sys_clk);
    check("full flags", {12'h000, bus.full_flag_n}, 16'h000E);
    check("empty flags", {12'h000, bus.empty_flag_n}, 16'h0001);
    cmd(SFS_CMD_WRITE, 2'h0, 16'hBEEF, 16'h0000);
    for (int i = 0; i < DEPTH; i++) cmd(SFS_CMD_READ, 2'h0, 16'h0000, 16'hA000 + 16'(i));
    wait_ready();
    repeat (2) @(negedge sys_clk);
    check("empty after drain", {12'h000, bus.empty_flag_n}, 16'h0000);
    for (int i = 0; i < 3; i++) cmd(SFS_CMD_WRITE, 2'h1, 16'h5A00 + 16'(i), 16'h0000);
    cmd(SFS_CMD_COMMIT, 2'h1, 16'h0000, 16'h0000);
    wait_ready();
    repeat (2) @(negedge sys_clk);
    check("packets", 16'(user_packets), 16'h0001);
    check("committed", 16'(user_committed), 16'h0003);
    for (int i = 0; i < 3; i++)
    begin
      check("host word", user_data, 16'h5A00 + 16'(i));
      user_pop = 1'b1;
      @(negedge sys_clk);
      user_pop = 1'b0;
      repeat (2) @(negedge sys_clk);
    end
    test_done();
  end
endmodule : test_slave_fifo_sync_port
